// file: design/psd_divider.sv
`timescale 1ns/1ns
`include "psd_map.svh"
module psd_divider
    import psd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        psc_clk_i,
    input  wire logic        ref_i,
    input  wire logic        ser_clk_i,
    input  wire logic        ser_dat_i,
    input  wire logic        ser_le_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    output logic             mod_sel_o,
    output logic             phase_up_o,
    output logic             phase_dn_o
);
    psd_sys_t               sq;
    psd_sys_t               next_sq;
    psd_lnk_t               lq;
    psd_lnk_t               next_lq;
    logic                   run;
    logic [`PSD_A_W-1:0]    a_eff;
    logic [`PSD_N_W-1:0]    n_load;
    logic                   last_pulse;
    logic                   ref_rise;
    logic                   sclk_rise;
    logic                   le_rise;
    logic                   ev_r;
    logic                   ev_v;
    logic [`PSD_R_W-1:0]    r_load;
    logic                   access;
    logic                   wr_done;

    // ----------------------------------------------------------------
    // prescaler-clock side: swallow and main counters
    // ----------------------------------------------------------------

    // single-counter mode forces the swallow count to zero
    assign run        = lq.en_s[1] & lq.ce_s[1];
    assign a_eff      = lq.shadow.single ? '0 : lq.shadow.a;
    assign n_load     = `PSD_N_W'(psd_nz(16'(lq.shadow.n)));
    assign last_pulse = (lq.n_left <= `PSD_N_W'(1));

    always_comb begin
        next_lq       = lq;
        next_lq.req_s = {lq.req_s[1:0], sq.req};
        next_lq.en_s  = {lq.en_s[0], sq.en};
        next_lq.ce_s  = {lq.ce_s[0], ce_i};
        // new divisors taken while the system side holds them still
        if (lq.req_s[2] != lq.req_s[1]) begin
            next_lq.shadow = sq.div_tx;
            next_lq.ack    = lq.req_s[1];
        end
        if (!run) begin
            // parked: ready to start a fresh cycle, with the larger modulus if the swallow count in effect is nonzero
            next_lq.n_left = n_load;
            next_lq.a_left = a_eff;
            next_lq.mod_hi = (a_eff != '0);
        end else if (last_pulse) begin
            // whole counter system restarts on this same pulse
            next_lq.n_left = n_load;
            next_lq.a_left = a_eff;
            next_lq.mod_hi = (a_eff != '0);
            next_lq.vtg    = ~lq.vtg;
        end else begin
            next_lq.n_left = lq.n_left - `PSD_N_W'(1);
            if (lq.a_left != '0) begin
                next_lq.a_left = lq.a_left - `PSD_A_W'(1);
            end
            // swallow full after this pulse drops to base modulus
            next_lq.mod_hi = (lq.a_left > `PSD_A_W'(1));
        end
    end

    // counters advance on prescaler output only, modulus line from a flop
    always_ff @(posedge psc_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lq        <= '0;
            lq.n_left <= `PSD_N_RST;
            lq.shadow <= '{single: 1'b0, n: `PSD_N_RST, a: `PSD_A_RST};
        end else if (lq.ce_s[1]) begin
            lq <= next_lq;
        end else begin
            // only the clock-enable synchroniser keeps running so the freeze can be lifted
            lq.ce_s <= next_lq.ce_s;
        end
    end

    // ----------------------------------------------------------------
    // system-clock side: reference divider, comparator, latches, bus
    // ----------------------------------------------------------------

    assign ref_rise  = sq.ref_s[1] & ~sq.ref_s[2];
    assign sclk_rise = sq.sclk_s[1] & ~sq.sclk_s[2];
    assign le_rise   = sq.sle_s[1] & ~sq.sle_s[2];
    assign ev_v      = sq.vtg_s[1] ^ sq.vtg_s[2];
    assign r_load    = psd_nz(sq.r);
    assign ev_r      = ref_rise & (sq.r_left <= `PSD_R_W'(1));
    assign access    = psel_i & penable_i & ~sq.pready;
    assign wr_done   = psel_i & penable_i & sq.pready & pwrite_i;

    always_comb begin
        next_sq        = sq;
        next_sq.ref_s  = {sq.ref_s[1:0], ref_i};
        next_sq.sclk_s = {sq.sclk_s[1:0], ser_clk_i};
        next_sq.sdat_s = {sq.sdat_s[0], ser_dat_i};
        next_sq.sle_s  = {sq.sle_s[1:0], ser_le_i};
        next_sq.vtg_s  = {sq.vtg_s[1:0], lq.vtg};
        next_sq.ack_s  = {sq.ack_s[0], lq.ack};

        // reference divider counts synchronised rising edges
        if (ref_rise) begin
            next_sq.r_left = ev_r ? r_load : sq.r_left - `PSD_R_W'(1);
        end

        // comparator: flags set by rising edges, cleared when both seen
        if ((ev_r | sq.up) & (ev_v | sq.dn)) begin
            next_sq.up = 1'b0;
            next_sq.dn = 1'b0;
        end else begin
            next_sq.up = sq.up | ev_r;
            next_sq.dn = sq.dn | ev_v;
        end
        next_sq.cycles = sq.cycles + `PSD_CYC_W'(ev_v);

        // serial load: last bit shifted is the select bit
        if (sclk_rise) begin
            next_sq.shift = {sq.shift[`PSD_SH_W-2:0], sq.sdat_s[1]};
        end
        if (le_rise) begin
            if (sq.shift[`PSD_SEL_BIT]) begin
                next_sq.r = sq.shift[`PSD_R_W:1];
            end else begin
                next_sq.div_lat.n = sq.shift[`PSD_SH_W-1:`PSD_A_W+1];
                next_sq.div_lat.a = sq.shift[`PSD_A_W:1];
                next_sq.pending   = 1'b1;
            end
        end

        // register writes take effect only at the completing edge
        if (wr_done && paddr_i == `PSD_OFF_CTRL) begin
            next_sq.en             = pwdata_i[`PSD_CTRL_EN];
            next_sq.div_lat.single = pwdata_i[`PSD_CTRL_SINGLE];
            next_sq.pending        = 1'b1;
        end

        // handshake: div_tx stays still until the far side echoes
        unique case (sq.xf)
            PSD_XF_IDLE: begin
                if (sq.pending) begin
                    next_sq.div_tx  = sq.div_lat;
                    next_sq.req     = ~sq.req;
                    next_sq.pending = 1'b0;
                    next_sq.xf      = PSD_XF_BUSY;
                end
            end
            PSD_XF_BUSY: begin
                if (sq.ack_s[1] == sq.req) begin
                    next_sq.xf = PSD_XF_IDLE;
                end
            end
        endcase

        // apb: answer one cycle into the access phase
        next_sq.pready  = access;
        next_sq.pslverr = 1'b0;
        next_sq.prdata  = '0;
        if (access) begin
            unique case (paddr_i)
                `PSD_OFF_CTRL:   next_sq.prdata = {30'h0, sq.div_lat.single, sq.en};
                `PSD_OFF_STATUS: next_sq.prdata = {29'h0, sq.xf == PSD_XF_BUSY,
                                                   sq.dn, sq.up};
                `PSD_OFF_DIVN:   next_sq.prdata = 32'(sq.div_lat.n);
                `PSD_OFF_DIVA:   next_sq.prdata = 32'(sq.div_lat.a);
                `PSD_OFF_DIVR:   next_sq.prdata = 32'(sq.r);
                `PSD_OFF_CYCLES: next_sq.prdata = 32'(sq.cycles);
                default:         next_sq.pslverr = 1'b1;
            endcase
        end
    end

    // system state, frozen while the clock enable is low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sq         <= '0;
            sq.div_lat <= '{single: 1'b0, n: `PSD_N_RST, a: `PSD_A_RST};
            sq.div_tx  <= '{single: 1'b0, n: `PSD_N_RST, a: `PSD_A_RST};
            sq.r       <= `PSD_R_RST;
            sq.r_left  <= `PSD_R_RST;
        end else if (ce_i) begin
            sq <= next_sq;
        end
    end

    // outputs straight from flops
    assign pready_o   = sq.pready;
    assign prdata_o   = sq.prdata;
    assign pslverr_o  = sq.pslverr;
    assign mod_sel_o  = lq.mod_hi;
    assign phase_up_o = sq.up;
    assign phase_dn_o = sq.dn;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------

    a_mod_start_high: assert property (@(posedge psc_clk_i) disable iff (!rst_n_i)
        (run && last_pulse) |=> (lq.mod_hi == (lq.a_left != '0)))
        else $error("modulus not larger at cycle start");

    a_mod_drops_full: assert property (@(posedge psc_clk_i) disable iff (!rst_n_i)
        (run && !last_pulse && lq.a_left == `PSD_A_W'(1)) |=> !lq.mod_hi)
        else $error("modulus not dropped when swallow full");

    a_base_phase_low: assert property (@(posedge psc_clk_i) disable iff (!rst_n_i)
        (run && !last_pulse && lq.a_left == '0) |=> !lq.mod_hi)
        else $error("modulus high during base phase");

    a_swallow_hold_hi: assert property (@(posedge psc_clk_i) disable iff (!rst_n_i)
        (run && !last_pulse && lq.a_left > `PSD_A_W'(1)) |=> lq.mod_hi)
        else $error("modulus dropped too early");

    a_cycle_reload: assert property (@(posedge psc_clk_i) disable iff (!rst_n_i)
        (run && last_pulse) |=> (lq.n_left == $past(n_load) && lq.vtg != $past(lq.vtg)))
        else $error("main counter not restarted at cycle end");

    a_main_countdown: assert property (@(posedge psc_clk_i) disable iff (!rst_n_i)
        (run && !last_pulse) |=> (lq.n_left == $past(lq.n_left) - `PSD_N_W'(1)))
        else $error("main counter did not step");

    a_ref_reload: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && ev_r) |=> (sq.r_left == $past(r_load)))
        else $error("reference divider not reloaded");

    a_pfd_ref_lead: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && ev_r && !ev_v && !sq.dn) |=> sq.up ##1 (sq.up || $past(ev_v)))
        else $error("reference lead not shown");

    a_pfd_both_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && sq.up && ev_v) |=> (!sq.up && !sq.dn))
        else $error("comparator flags not cleared");

    a_latch_copy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && le_rise && !sq.shift[`PSD_SEL_BIT])
        |=> (sq.div_lat.n == $past(sq.shift[`PSD_SH_W-1:`PSD_A_W+1])))
        else $error("divisor not latched on pulse");

    c_cycle_end:  cover property (@(posedge psc_clk_i) disable iff (!rst_n_i)
        run && last_pulse);
    c_mod_drop:   cover property (@(posedge psc_clk_i) disable iff (!rst_n_i)
        lq.mod_hi ##1 !lq.mod_hi);
    c_ref_event:  cover property (@(posedge clk_i) disable iff (!rst_n_i) ev_r);
    c_xfer_done:  cover property (@(posedge clk_i) disable iff (!rst_n_i)
        sq.xf == PSD_XF_BUSY ##1 sq.xf == PSD_XF_IDLE);
endmodule : psd_divider

// file: design/psd_map.svh
`ifndef PSD_MAP_SVH
`define PSD_MAP_SVH
// Behaviour
// - each division cycle with a nonzero swallow count, outside single-counter mode, starts with the prescaler commanded to its larger modulus
// - once the swallow count is used up, the modulus line drops to base
// - after the remaining main-count pulses, restart both counters, with the larger modulus unless the swallow count is zero or single-counter mode is set
// - one main cycle spans main count times base modulus plus swallow count
// - reference divider divides the reference by its loaded ratio for comparison
// - main and swallow counters run on prescaler output pulses only
// - in single-counter mode a main count step moves the divide by the base modulus
// - divide value up to 18 bits, reference ratio up to 16 bits
// - divisors shift in serially and a latch pulse copies them into latches
// - at main count end the whole counter system resets within one pulse
// - comparator acts on rising edges only and shows which input leads

// ----------------------------------------------------------------
// counter widths
// ----------------------------------------------------------------
`define PSD_N_W         11
`define PSD_A_W         7
`define PSD_R_W         16
`define PSD_SH_W        19
`define PSD_CYC_W       16

// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define PSD_OFF_CTRL    8'h00
`define PSD_OFF_STATUS  8'h04
`define PSD_OFF_DIVN    8'h08
`define PSD_OFF_DIVA    8'h0c
`define PSD_OFF_DIVR    8'h10
`define PSD_OFF_CYCLES  8'h14
`define PSD_CTRL_EN     0
`define PSD_CTRL_SINGLE 1
`define PSD_ST_UP       0
`define PSD_ST_DN       1
`define PSD_ST_BUSY     2
`define PSD_SEL_BIT     0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PSD_N_RST       11'h010
`define PSD_A_RST       7'h00
`define PSD_R_RST       16'h0001
`endif

// file: design/psd_pkg.sv
`include "psd_map.svh"
package psd_pkg;
    // latch-to-counter transfer handshake
    typedef enum logic {
        PSD_XF_IDLE = 1'b0,
        PSD_XF_BUSY = 1'b1
    } psd_xf_t;

    // divisor set handed to the prescaler-clock side
    typedef struct packed {
        logic                  single;
        logic [`PSD_N_W-1:0]   n;
        logic [`PSD_A_W-1:0]   a;
    } psd_div_t;

    // state on the system clock
    typedef struct packed {
        logic                  en;
        logic [2:0]            ref_s;
        logic [2:0]            sclk_s;
        logic [1:0]            sdat_s;
        logic [2:0]            sle_s;
        logic [2:0]            vtg_s;
        logic [1:0]            ack_s;
        logic [`PSD_SH_W-1:0]  shift;
        psd_div_t              div_lat;
        psd_div_t              div_tx;
        logic [`PSD_R_W-1:0]   r;
        logic [`PSD_R_W-1:0]   r_left;
        psd_xf_t               xf;
        logic                  req;
        logic                  pending;
        logic                  up;
        logic                  dn;
        logic [`PSD_CYC_W-1:0] cycles;
        logic                  pready;
        logic [31:0]           prdata;
        logic                  pslverr;
    } psd_sys_t;

    // state on the prescaler output clock
    typedef struct packed {
        logic [2:0]            req_s;
        logic [1:0]            en_s;
        logic [1:0]            ce_s;
        psd_div_t              shadow;
        logic                  ack;
        logic [`PSD_N_W-1:0]   n_left;
        logic [`PSD_A_W-1:0]   a_left;
        logic                  mod_hi;
        logic                  vtg;
    } psd_lnk_t;

    // zero ratio is treated as one
    function automatic logic [15:0] psd_nz(input logic [15:0] v);
        psd_nz = (v == 16'h0000) ? 16'h0001 : v;
    endfunction : psd_nz
endpackage : psd_pkg

// file: testbench/psd_psc_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// dual-modulus prescaler fed by a free-running oscillator
// ----------------------------------------------------------------
module psd_psc_model #(
    parameter int M = 6
) (
    input  wire logic  mod_sel_i,
    output logic       psc_clk_o,
    output logic [31:0] span_o,
    output logic [31:0] rises_o
);
    logic        vco = 1'b0;
    logic [31:0] vcnt = 32'h0;
    logic [31:0] last = 32'h0;
    int          ph = 0;
    int          len = M;

    initial begin
        psc_clk_o = 1'b0;
        span_o = 32'h0;
        rises_o = 32'h0;
    end

    // 2 ns oscillator from 4 ns on; its rising edges also land on system clock edges
    initial begin
        #3;
        forever #1 vco = ~vco;
    end

    // output pulse per modulus; modulus taken in the high half, ahead of the
    // long low half, so a late change of the select line costs no margin
    always @(posedge vco) begin
        vcnt <= vcnt + 32'h1;
        if (ph == len - 1) begin
            ph <= 0;
            psc_clk_o <= 1'b1;
        end else begin
            ph <= ph + 1;
            if (ph == M / 2 - 1) begin
                psc_clk_o <= 1'b0;
                len <= mod_sel_i ? M + 1 : M;
            end
        end
    end

    // oscillator cycles between two starts of a division cycle
    always @(posedge mod_sel_i) begin
        span_o <= vcnt - last;
        last <= vcnt;
        rises_o <= rises_o + 32'h1;
    end
endmodule : psd_psc_model

// file: testbench/tb_top.sv
`timescale 1ns/1ns
`include "psd_map.svh"
module tb_top;
    localparam int M = 6;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        ce_i = 1'b1;
    logic        ref_i = 1'b0;
    logic        ser_clk_i = 1'b0;
    logic        ser_dat_i = 1'b0;
    logic        ser_le_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic        pready_o;
    logic        pslverr_o;
    logic        mod_sel_o;
    logic        phase_up_o;
    logic        phase_dn_o;
    logic        psc_clk;
    logic [31:0] prdata_o;
    logic [31:0] span;
    logic [31:0] rises;
    int          fail_count = 0;
    int          total_checks = 0;
    int          cyc = 0;

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    psd_divider i_psd_divider (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .psc_clk_i(psc_clk), .ref_i(ref_i), .ser_clk_i(ser_clk_i),
        .ser_dat_i(ser_dat_i), .ser_le_i(ser_le_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
        .pslverr_o(pslverr_o), .mod_sel_o(mod_sel_o), .phase_up_o(phase_up_o),
        .phase_dn_o(phase_dn_o));

    psd_psc_model #(.M(M)) i_psd_psc_model (.mod_sel_i(mod_sel_o),
        .psc_clk_o(psc_clk), .span_o(span), .rises_o(rises));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic wrap_up;
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h0, d, e);
        chk(d, exp);
    endtask : rd_chk

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1'b1, a, wd, d, e);
    endtask : wr

    // msb first, slow enough for the pin synchronisers, latch with clock idle
    task automatic ser_load(input logic [18:0] w);
        for (int i = 18; i >= 0; i--) begin
            ser_dat_i <= w[i];
            repeat (4) @(posedge clk_i);
            ser_clk_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            ser_clk_i <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        ser_le_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        ser_le_i <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask : ser_load

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] d;
        logic        e;
        rd_chk(`PSD_OFF_CTRL, 32'h0);
        rd_chk(`PSD_OFF_DIVN, 32'h10);
        rd_chk(`PSD_OFF_DIVA, 32'h0);
        rd_chk(`PSD_OFF_DIVR, 32'h1);
        rd_chk(`PSD_OFF_CYCLES, 32'h0);
        wr(`PSD_OFF_DIVN, 32'h55);
        rd_chk(`PSD_OFF_DIVN, 32'h10);
        apb(1'b0, 8'h18, 32'h0, d, e);
        chk(d, 32'h0);
        chk({31'h0, e}, 32'h1);
    endtask : t_reset

    task automatic t_ratio;
        ser_load({2'b00, 16'hffff, 1'b1});
        rd_chk(`PSD_OFF_DIVR, 32'hffff);
        ser_load({2'b00, 16'h0005, 1'b1});
        rd_chk(`PSD_OFF_DIVR, 32'h5);
    endtask : t_ratio

    // load n and a, then enable and clear single mode; the third cycle after is fully new
    task automatic run_div(input logic [10:0] n, input logic [6:0] a);
        logic [31:0] k;
        ser_load({n, a, 1'b0});
        rd_chk(`PSD_OFF_DIVN, {21'h0, n});
        rd_chk(`PSD_OFF_DIVA, {25'h0, a});
        wr(`PSD_OFF_CTRL, 32'h1);
        k = rises;
        wait (rises >= k + 32'h3);
        chk(span, 32'(n) * M + 32'(a));
    endtask : run_div

    // clock enable low: no division cycle may start while frozen
    task automatic t_freeze;
        logic [31:0] k;
        ce_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        k = rises;
        repeat (200) @(posedge clk_i);
        chk(rises, k);
        ce_i <= 1'b1;
        repeat (100) @(posedge clk_i);
        chk({31'h0, rises != k}, 32'h1);
    endtask : t_freeze

    task automatic t_single;
        ser_load({11'd10, 7'd3, 1'b0});
        wr(`PSD_OFF_CTRL, 32'h3);
        repeat (40) @(posedge clk_i);
        repeat (30) begin
            @(posedge clk_i);
            chk({31'h0, mod_sel_o}, 32'h0);
        end
    endtask : t_single

    // long cycle leaves a quiet gap for reference edges to lead
    task automatic t_phase;
        logic [31:0] k;
        k = rises;
        wait (rises != k);
        repeat (20) begin
            ref_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            ref_i <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
        repeat (8) @(posedge clk_i);
        chk({30'h0, phase_dn_o, phase_up_o}, 32'h1);
        rd_chk(`PSD_OFF_STATUS, 32'h1);
    endtask : t_phase

    // ----------------------------------------------------------------
    // sequence and hang guard
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_ratio();
        run_div(11'd20, 7'd3);
        run_div(11'd20, 7'd4);
        t_freeze();
        t_single();
        run_div(11'h7ff, 7'd1);
        t_phase();
        wrap_up();
    end

    // whole run needs well under 8000 cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
endmodule : tb_top
